// ---- hw/bcd_pkg.sv ----
// Package: opcode classes, selectors, byte counts and cycle counts for the opcode decoder
package bcd_pkg;

	localparam int unsigned BYTE_W = 8;

	// Operation classes
	typedef enum logic [4:0] {
		BCD_OP_NONE        = 5'h00,
		BCD_OP_MOVE        = 5'h01,
		BCD_OP_STORE_M     = 5'h02,
		BCD_OP_LOAD_M      = 5'h03,
		BCD_OP_MOVE_IMM    = 5'h04,
		BCD_OP_PAIR_IMM    = 5'h05,
		BCD_OP_SWAP_PAIRS  = 5'h06,
		BCD_OP_PUSH        = 5'h07,
		BCD_OP_POP         = 5'h08,
		BCD_OP_SWAP_STACK  = 5'h09,
		BCD_OP_SP_FROM_HL  = 5'h0a,
		BCD_OP_PAIR_INC    = 5'h0b,
		BCD_OP_PAIR_DEC    = 5'h0c,
		BCD_OP_BRANCH      = 5'h0d,
		BCD_OP_EXIT        = 5'h0e,
		BCD_OP_CALL        = 5'h0f,
		BCD_OP_RESTART     = 5'h10,
		BCD_OP_ADD         = 5'h11,
		BCD_OP_ADD_CARRY   = 5'h12,
		BCD_OP_OTHER       = 5'h13
	} bcd_op_t;

	// Register selector codes
	localparam logic [2:0] SEL_B   = 3'h0;
	localparam logic [2:0] SEL_C   = 3'h1;
	localparam logic [2:0] SEL_D   = 3'h2;
	localparam logic [2:0] SEL_E   = 3'h3;
	localparam logic [2:0] SEL_H   = 3'h4;
	localparam logic [2:0] SEL_L   = 3'h5;
	localparam logic [2:0] SEL_MEM = 3'h6;
	localparam logic [2:0] SEL_A   = 3'h7;

	// Pair codes; 11 means the stack pointer, or the accumulator-flags word on the stack
	localparam logic [1:0] PAIR_BC = 2'h0;
	localparam logic [1:0] PAIR_DE = 2'h1;
	localparam logic [1:0] PAIR_HL = 2'h2;
	localparam logic [1:0] PAIR_SP = 2'h3;

	// Instruction lengths
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;

	// Clock-cycle counts
	localparam logic [4:0] CYC_4  = 5'h04;
	localparam logic [4:0] CYC_5  = 5'h05;
	localparam logic [4:0] CYC_7  = 5'h07;
	localparam logic [4:0] CYC_10 = 5'h0a;
	localparam logic [4:0] CYC_11 = 5'h0b;
	localparam logic [4:0] CYC_13 = 5'h0d;
	localparam logic [4:0] CYC_16 = 5'h10;
	localparam logic [4:0] CYC_17 = 5'h11;
	localparam logic [4:0] CYC_18 = 5'h12;

	// Values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_CNT  = 2'h0;
	localparam logic [4:0] RST_CYC  = 5'h00;

endpackage : bcd_pkg

// ---- hw/bcd_decoder.sv ----
// Opcode decoder: sorts the first byte, gathers operand bytes, gives class and counts
// Notes on behaviour
// [RULE_01] Every byte handled as 8-bit binary integer
// [RULE_02] Length from first byte; fetch that many
// [RULE_03] Memory holds instruction bytes at consecutive addresses
// [RULE_04] Register, stack, return opcodes are one byte
// [RULE_05] Immediate and port opcodes take one operand
// [RULE_06] Branch, call, direct load/store take three bytes
// [RULE_07] Second byte low, third byte high
// [RULE_08] Positive logic on every bit
// [RULE_09] Register move 01DDDSSS, five cycles
// [RULE_10] Memory store and load via HL, seven
// [RULE_11] Pair immediate load 00PP0001, ten cycles
// [RULE_12] Swap DE with HL, four cycles
// [RULE_13] Push pair 11PP0101, eleven cycles
// [RULE_14] Accumulator-flags push eleven, pop ten cycles
// [RULE_15] Pop pair 11PP0001, ten cycles
// [RULE_16] Swap stack top with HL, eighteen
// [RULE_17] Stack pointer load, copy, increment, decrement
// [RULE_18] Branch unconditional or on condition, ten
// [RULE_19] Exit ten; conditional exit five or eleven
// [RULE_20] Pair increment/decrement, five cycles
// [RULE_21] Add and add-with-carry register, four cycles
// [RULE_22] Selector codes B..L, memory 110, A 111
// [RULE_23] Restart is one-byte call to vector
// [RULE_24] Failed condition uses shorter count
// [RULE_25] Call seventeen; conditional call eleven or seventeen
`timescale 1ns/100ps
module bcd_decoder
	import bcd_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic        i_byte_valid,
	input  wire logic [7:0]  i_byte,
	input  wire logic        i_cond_true,
	output logic             o_byte_ready,
	output logic             o_instr_valid,
	output logic [7:0]       o_opcode,
	output logic [15:0]      o_operand,
	output logic [1:0]       o_length,
	output bcd_op_t          o_op_class,
	output logic [2:0]       o_dest_sel,
	output logic [2:0]       o_src_sel,
	output logic [1:0]       o_pair_sel,
	output logic [2:0]       o_cond_sel,
	output logic             o_cond_used,
	output logic             o_taken,
	output logic [15:0]      o_restart_vec,
	output logic [4:0]       o_cycles
);

	typedef enum logic [2:0] {
		BCD_ST_OPC = 3'b001,
		BCD_ST_LO  = 3'b010,
		BCD_ST_HI  = 3'b100
	} bcd_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// First-byte classification

	bcd_state_t state_q, state_d;
	logic [7:0] opc_q;
	logic [7:0] lo_q;
	logic       take;
	logic [1:0] len_w;
	bcd_op_t    cls_w;
	logic [4:0] cyc_short_w, cyc_long_w;
	logic       cond_w;

	// Decode the byte that sits in the opcode holding register (or arriving in it)
	logic [7:0] dec_byte;
	assign dec_byte = (state_q == BCD_ST_OPC) ? i_byte : opc_q;

	wire [1:0] grp = dec_byte[7:6];
	wire [2:0] mid = dec_byte[5:3];
	wire [2:0] low = dec_byte[2:0];
	wire [1:0] pp  = dec_byte[5:4];

	always_comb begin
		cls_w       = BCD_OP_OTHER;
		len_w       = LEN_1;                                 // [RULE_04]
		cyc_short_w = CYC_4;
		cyc_long_w  = CYC_4;
		cond_w      = 1'b0;
		unique case (grp)
			2'b01: begin
				if (mid == SEL_MEM && low == SEL_MEM) begin
					cls_w = BCD_OP_OTHER;                    // Halt
					cyc_short_w = CYC_7;
				end else if (mid == SEL_MEM) begin
					cls_w = BCD_OP_STORE_M;                  // [RULE_10] [RULE_22]
					cyc_short_w = CYC_7;
				end else if (low == SEL_MEM) begin
					cls_w = BCD_OP_LOAD_M;                   // [RULE_10]
					cyc_short_w = CYC_7;
				end else begin
					cls_w = BCD_OP_MOVE;                     // [RULE_09]
					cyc_short_w = CYC_5;
				end
			end
			2'b00: begin
				if (low == 3'h6) begin
					cls_w = BCD_OP_MOVE_IMM;
					len_w = LEN_2;                           // [RULE_05]
					cyc_short_w = (mid == SEL_MEM) ? CYC_10 : CYC_7;
				end else if (dec_byte[3:0] == 4'h1) begin
					cls_w = BCD_OP_PAIR_IMM;                 // [RULE_11] [RULE_17]
					len_w = LEN_3;                           // [RULE_06]
					cyc_short_w = CYC_10;
				end else if (dec_byte[3:0] == 4'h3) begin
					cls_w = BCD_OP_PAIR_INC;                 // [RULE_20] [RULE_17]
					cyc_short_w = CYC_5;
				end else if (dec_byte[3:0] == 4'hb) begin
					cls_w = BCD_OP_PAIR_DEC;                 // [RULE_20] [RULE_17]
					cyc_short_w = CYC_5;
				end else if (low == 3'h2 && dec_byte[5]) begin
					len_w = LEN_3;                           // Direct load and store [RULE_06]
					cyc_short_w = dec_byte[4] ? CYC_13 : CYC_16;
				end else if (low == 3'h2) begin
					cyc_short_w = CYC_7;
				end else if (low == 3'h4 || low == 3'h5) begin
					cyc_short_w = (mid == SEL_MEM) ? CYC_10 : CYC_5;
				end else if (low == 3'h1) begin
					cyc_short_w = CYC_10;                    // Double add
				end
			end
			2'b10: begin
				cyc_short_w = (low == SEL_MEM) ? CYC_7 : CYC_4;
				if (mid == 3'h0)
					cls_w = BCD_OP_ADD;                      // [RULE_21]
				else if (mid == 3'h1)
					cls_w = BCD_OP_ADD_CARRY;                // [RULE_21]
			end
			2'b11: begin
				unique case (low)
					3'h0: begin
						cls_w = BCD_OP_EXIT;                 // [RULE_19]
						cond_w = 1'b1;
						cyc_short_w = CYC_5;
						cyc_long_w = CYC_11;
					end
					3'h1: begin
						if (dec_byte[3] == 1'b0) begin
							cls_w = BCD_OP_POP;              // [RULE_15] [RULE_14]
							cyc_short_w = CYC_10;
						end else if (pp == 2'h0) begin
							cls_w = BCD_OP_EXIT;             // [RULE_19]
							cyc_short_w = CYC_10;
						end else if (pp == 2'h3) begin
							cls_w = BCD_OP_SP_FROM_HL;       // [RULE_17]
							cyc_short_w = CYC_5;
						end else begin
							cyc_short_w = CYC_5;             // Pair to program counter
						end
					end
					3'h2: begin
						cls_w = BCD_OP_BRANCH;               // [RULE_18]
						cond_w = 1'b1;
						len_w = LEN_3;
						cyc_short_w = CYC_10;
						cyc_long_w = CYC_10;
					end
					3'h3: begin
						if (mid == 3'h0) begin
							cls_w = BCD_OP_BRANCH;           // [RULE_18]
							len_w = LEN_3;
							cyc_short_w = CYC_10;
						end else if (mid == 3'h4) begin
							cls_w = BCD_OP_SWAP_STACK;       // [RULE_16]
							cyc_short_w = CYC_18;
						end else if (mid == 3'h5) begin
							cls_w = BCD_OP_SWAP_PAIRS;       // [RULE_12]
						end else if (mid == 3'h2 || mid == 3'h3) begin
							len_w = LEN_2;                   // Port number [RULE_05]
							cyc_short_w = CYC_10;
						end
					end
					3'h4: begin
						cls_w = BCD_OP_CALL;                 // [RULE_25]
						cond_w = 1'b1;
						len_w = LEN_3;
						cyc_short_w = CYC_11;
						cyc_long_w = CYC_17;
					end
					3'h5: begin
						if (dec_byte[3] == 1'b0) begin
							cls_w = BCD_OP_PUSH;             // [RULE_13] [RULE_14]
							cyc_short_w = CYC_11;
						end else if (pp == 2'h0) begin
							cls_w = BCD_OP_CALL;             // [RULE_25]
							len_w = LEN_3;
							cyc_short_w = CYC_17;
						end
					end
					3'h6: begin
						len_w = LEN_2;                       // Immediate arithmetic [RULE_05]
						cyc_short_w = CYC_7;
						if (mid == 3'h0)
							cls_w = BCD_OP_ADD;
						else if (mid == 3'h1)
							cls_w = BCD_OP_ADD_CARRY;
					end
					3'h7: begin
						cls_w = BCD_OP_RESTART;              // [RULE_23]
						cyc_short_w = CYC_11;
					end
				endcase
				if (!cond_w)
					cyc_long_w = cyc_short_w;
			end
		endcase
		if (grp != 2'b11)
			cyc_long_w = cyc_short_w;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Byte gathering

	assign o_byte_ready = 1'b1;
	assign take = i_byte_valid;

	wire done_w = take && ((state_q == BCD_ST_OPC && len_w == LEN_1) ||
	                       (state_q == BCD_ST_LO && len_w == LEN_2) ||
	                       (state_q == BCD_ST_HI));          // [RULE_02]

	// Bytes arrive in address order, so the gatherer needs no addresses [RULE_03]
	always_comb begin
		state_d = state_q;
		if (take) begin
			unique case (state_q)
				BCD_ST_OPC: state_d = (len_w == LEN_1) ? BCD_ST_OPC : BCD_ST_LO;
				BCD_ST_LO:  state_d = (len_w == LEN_3) ? BCD_ST_HI : BCD_ST_OPC;
				BCD_ST_HI:  state_d = BCD_ST_OPC;
				default:    state_d = BCD_ST_OPC;
			endcase
		end
	end

	// Condition is sampled with the final byte, so a conditional exit resolves at once
	wire taken_w = !cond_w || i_cond_true;                   // [RULE_24]

	// Operand as it stands once the final byte is in; one-byte opcodes carry none
	logic [15:0] operand_w;
	assign operand_w = (state_q == BCD_ST_OPC) ? 16'h0000 :
	                   (state_q == BCD_ST_LO)  ? {8'h00, i_byte} :  // [RULE_05]
	                                             {i_byte, lo_q};    // [RULE_07]

	wire [4:0]  cycles_w = taken_w ? cyc_long_w : cyc_short_w;  // [RULE_24] [RULE_19]
	wire [15:0] vector_w = {10'h000, mid, 3'h0};                 // [RULE_23]

	////////////////////////////////////////////////////////////////////////////////
	// Gathering registers

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_q <= BCD_ST_OPC;
			opc_q   <= RST_BYTE;
			lo_q    <= RST_BYTE;
		end else begin
			state_q <= state_d;
			if (take && state_q == BCD_ST_OPC)
				opc_q <= i_byte;                             // [RULE_01] [RULE_08]
			if (take && state_q == BCD_ST_LO)
				lo_q <= i_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Results other than o_instr_valid, held from one finished instruction to the next so a slow sequencer can read late

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_instr_valid <= 1'b0;
			o_opcode      <= RST_BYTE;
			o_operand     <= {RST_BYTE, RST_BYTE};
			o_length      <= RST_CNT;
			o_op_class    <= BCD_OP_NONE;
			o_dest_sel    <= SEL_B;
			o_src_sel     <= SEL_B;
			o_pair_sel    <= PAIR_BC;
			o_cond_sel    <= 3'h0;
			o_cond_used   <= 1'b0;
			o_taken       <= 1'b0;
			o_restart_vec <= {RST_BYTE, RST_BYTE};
			o_cycles      <= RST_CYC;
		end else begin
			o_instr_valid <= done_w;
			if (done_w) begin
				o_opcode      <= dec_byte;
				o_length      <= len_w;
				o_op_class    <= cls_w;
				o_dest_sel    <= mid;                        // [RULE_22]
				o_src_sel     <= low;                        // [RULE_22]
				o_pair_sel    <= pp;
				o_cond_sel    <= mid;                        // [RULE_18]
				o_cond_used   <= cond_w;
				o_taken       <= taken_w;
				o_cycles      <= cycles_w;                   // [RULE_24] [RULE_19]
				o_restart_vec <= vector_w;                   // [RULE_23]
				o_operand     <= operand_w;                  // [RULE_05] [RULE_07]
			end
		end
	end

endmodule : bcd_decoder

// ---- testbench/bcd_decoder_sva.sv ----
// Checker: decoded outputs against the byte stream and opcode fields
`timescale 1ns/100ps
module bcd_decoder_sva
	import bcd_pkg::*;
(
	input wire logic        i_clk_sys,
	input wire logic        i_rst_n,
	input wire logic        i_byte_valid,
	input wire logic [7:0]  i_byte,
	input wire logic        i_cond_true,
	input wire logic        o_instr_valid,
	input wire logic [7:0]  o_opcode,
	input wire logic [15:0] o_operand,
	input wire logic [1:0]  o_length,
	input wire bcd_op_t     o_op_class,
	input wire logic [2:0]  o_dest_sel,
	input wire logic [2:0]  o_src_sel,
	input wire logic        o_taken,
	input wire logic [15:0] o_restart_vec,
	input wire logic [4:0]  o_cycles
);
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	chk_valid_cause: assert property (
		o_instr_valid |-> $past(i_byte_valid))
		else $error("result without a byte taken");
	chk_one_byte: assert property (
		o_instr_valid && o_length == LEN_1 |-> o_opcode == $past(i_byte))
		else $error("opcode not the last byte");
	chk_two_byte: assert property (
		o_instr_valid && o_length == LEN_2 |-> o_operand == {8'h00, $past(i_byte)})
		else $error("bad immediate operand");
	chk_high_byte: assert property (
		o_instr_valid && o_length == LEN_3 |-> o_operand[15:8] == $past(i_byte))
		else $error("third byte not high");
	chk_move_fields: assert property (
		o_instr_valid && o_op_class == BCD_OP_MOVE |-> o_cycles == CYC_5
		&& o_dest_sel == o_opcode[5:3] && o_src_sel == o_opcode[2:0])
		else $error("bad move decode");
	chk_exit_count: assert property (
		o_instr_valid && o_op_class == BCD_OP_EXIT && !o_opcode[0] |-> o_taken ==
		$past(i_cond_true) && o_cycles == ($past(i_cond_true) ? CYC_11 : CYC_5))
		else $error("bad conditional exit count");
	chk_restart_vec: assert property (
		o_instr_valid && o_op_class == BCD_OP_RESTART |->
		o_restart_vec == {10'h000, o_opcode[5:3], 3'h0})
		else $error("bad restart vector");
	chk_outs_held: assert property (
		!o_instr_valid && $past(i_rst_n) |-> $stable(o_cycles) && $stable(o_operand))
		else $error("result changed between instructions");
	cov_branch: cover property (o_instr_valid && o_op_class == BCD_OP_BRANCH);
	cov_exit_taken: cover property (o_instr_valid && o_op_class == BCD_OP_EXIT && o_taken);
	cov_three: cover property (o_instr_valid && o_length == LEN_3);
endmodule : bcd_decoder_sva
bind bcd_decoder bcd_decoder_sva bcd_decoder_sva_inst (.*);

// ---- testbench/bcd_prog_mem.sv ----
// Program memory model: streams up to three instruction bytes in address order
`timescale 1ns/100ps
module bcd_prog_mem (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_start,
	input  wire logic [1:0] i_len,
	input  wire logic       i_slow,
	output logic            o_byte_valid,
	output logic [7:0]      o_byte
);
	logic [7:0] rom [0:2];
	logic [1:0] idx_q;
	logic       busy_q;
	logic       gap_q;
	wire  [1:0] idx_w = i_start ? 2'h0 : idx_q;
	wire        send_w = i_start || (busy_q && (gap_q || !i_slow));
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			busy_q <= 1'b0;
			gap_q <= 1'b0;
			idx_q <= 2'h0;
			o_byte_valid <= 1'b0;
			o_byte <= 8'h5a;
		end else if (send_w) begin
			o_byte_valid <= 1'b1;
			o_byte <= rom[idx_w];
			idx_q <= idx_w + 2'h1;
			busy_q <= (idx_w + 2'h1) < i_len;
			gap_q <= 1'b0;
		end else begin
			// No pull on the bus: idle byte flips so a stale value is never reused
			o_byte_valid <= 1'b0;
			o_byte <= ~o_byte;
			gap_q <= busy_q;
		end
	end
endmodule : bcd_prog_mem

// ---- testbench/testbench.sv ----
// Testbench: bytes from the memory model, decoded results compared
`timescale 1ns/100ps
module testbench;
	import bcd_pkg::*;
	logic        i_clk_sys = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_cond_true = 1'b0;
	logic        i_start = 1'b0;
	logic        i_slow = 1'b0;
	logic [1:0]  i_len = 2'h1;
	logic        i_byte_valid, o_byte_ready, o_instr_valid, o_cond_used, o_taken;
	logic [7:0]  i_byte, o_opcode;
	logic [15:0] o_operand, o_restart_vec;
	logic [1:0]  o_length, o_pair_sel;
	logic [2:0]  o_dest_sel, o_src_sel, o_cond_sel;
	logic [4:0]  o_cycles;
	bcd_op_t     o_op_class;
	int          error_cnt = 0;
	int          comparisons = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	bcd_decoder bcd_decoder_inst (.*);
	bcd_prog_mem bcd_prog_mem_inst (.o_byte_valid(i_byte_valid), .o_byte(i_byte), .*);
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// Streams one instruction from the model; the condition is held through its last byte
	task automatic run(input logic [7:0] b0, b1, b2, input logic [1:0] n,
		input logic sl, cd, input bcd_op_t cl, input logic [4:0] cy);
		int k;
		bcd_prog_mem_inst.rom[0] = b0;
		bcd_prog_mem_inst.rom[1] = b1;
		bcd_prog_mem_inst.rom[2] = b2;
		@(posedge i_clk_sys);
		i_start <= 1'b1;
		i_len <= n;
		i_slow <= sl;
		i_cond_true <= cd;
		@(posedge i_clk_sys);
		i_start <= 1'b0;
		#1;
		for (k = 0; k < 12 && o_instr_valid !== 1'b1; k++) begin
			@(posedge i_clk_sys);
			#1;
		end
		cmp(o_instr_valid, 1'b1);
		cmp(o_opcode, b0);
		cmp(o_length, n);
		cmp(o_op_class, cl);
		cmp(o_cycles, cy);
		if (n == LEN_3)
			cmp(o_operand, {b2, b1});
		if (n == LEN_2)
			cmp(o_operand, {8'h00, b1});
	endtask : run
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		cmp(o_byte_ready, 1'b1);
		cmp(o_instr_valid, 1'b0);
		cmp(o_op_class, BCD_OP_NONE);
		cmp(o_cycles, RST_CYC);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_single;
		logic [7:0] op [19] = '{8'h41, 8'h7e, 8'heb, 8'hc5, 8'hf5, 8'hf1, 8'hd1, 8'he3, 8'hf9,
			8'h33, 8'h3b, 8'h23, 8'h1b, 8'hc9, 8'h80, 8'h8f, 8'h70, 8'h76, 8'hff};
		bcd_op_t cl [19] = '{BCD_OP_MOVE, BCD_OP_LOAD_M, BCD_OP_SWAP_PAIRS, BCD_OP_PUSH,
			BCD_OP_PUSH, BCD_OP_POP, BCD_OP_POP, BCD_OP_SWAP_STACK, BCD_OP_SP_FROM_HL,
			BCD_OP_PAIR_INC, BCD_OP_PAIR_DEC, BCD_OP_PAIR_INC, BCD_OP_PAIR_DEC, BCD_OP_EXIT,
			BCD_OP_ADD, BCD_OP_ADD_CARRY, BCD_OP_STORE_M, BCD_OP_OTHER, BCD_OP_RESTART};
		logic [4:0] cy [19] = '{CYC_5, CYC_7, CYC_4, CYC_11, CYC_11, CYC_10, CYC_10, CYC_18,
			CYC_5, CYC_5, CYC_5, CYC_5, CYC_5, CYC_10, CYC_4, CYC_4, CYC_7, CYC_7, CYC_11};
		for (int i = 0; i < 19; i++) begin
			run(op[i], 8'h00, 8'h00, LEN_1, 1'b0, 1'b0, cl[i], cy[i]);
			cmp(o_pair_sel, op[i][5:4]);
			cmp(o_src_sel, op[i][2:0]);
			cmp(o_dest_sel, op[i][5:3]);
		end
		cmp(o_restart_vec, 16'h0038);
		$display("t_single done");
	endtask : t_single
	task automatic t_multi;
		run(8'h21, 8'h34, 8'h12, LEN_3, 1'b1, 1'b0, BCD_OP_PAIR_IMM, CYC_10);
		cmp(o_pair_sel, PAIR_HL);
		run(8'h31, 8'hcd, 8'hab, LEN_3, 1'b0, 1'b0, BCD_OP_PAIR_IMM, CYC_10);
		cmp(o_pair_sel, PAIR_SP);
		run(8'h3e, 8'ha5, 8'h00, LEN_2, 1'b1, 1'b0, BCD_OP_MOVE_IMM, CYC_7);
		cmp(o_dest_sel, SEL_A);
		run(8'hc3, 8'h00, 8'h80, LEN_3, 1'b0, 1'b0, BCD_OP_BRANCH, CYC_10);
		cmp(o_taken, 1'b1);
		cmp(o_cond_used, 1'b0);
		run(8'hcd, 8'hff, 8'h01, LEN_3, 1'b1, 1'b0, BCD_OP_CALL, CYC_17);
		run(8'hdb, 8'h7f, 8'h00, LEN_2, 1'b0, 1'b0, BCD_OP_OTHER, CYC_10);
		run(8'h3a, 8'h10, 8'h20, LEN_3, 1'b1, 1'b0, BCD_OP_OTHER, CYC_13);
		run(8'h22, 8'h44, 8'h33, LEN_3, 1'b0, 1'b0, BCD_OP_OTHER, CYC_16);
		$display("t_multi done");
	endtask : t_multi
	task automatic t_cond;
		logic [2:0] c;
		logic       t;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			t = c[0];
			run({2'h3, c, 3'h2}, 8'h55, 8'haa, LEN_3, c[1], t, BCD_OP_BRANCH, CYC_10);
			cmp(o_cond_sel, c);
			cmp(o_taken, t);
			run({2'h3, c, 3'h0}, 8'h0, 8'h0, LEN_1, 1'b0, t, BCD_OP_EXIT, t ? CYC_11 : CYC_5);
			run({2'h3, c, 3'h4}, 8'h1, 8'h2, LEN_3, 1'b0, !t, BCD_OP_CALL, t ? CYC_11 : CYC_17);
			cmp(o_cond_used, 1'b1);
		end
		$display("t_cond done");
	endtask : t_cond
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		@(posedge i_clk_sys);
		#1;
		t_reset();
		t_single();
		t_multi();
		t_cond();
		give_verdict();
	end
	// About 50 instructions of at most 12 cycles each; ten times that before giving up
	initial begin
		#60000;
		error_cnt++;
		give_verdict();
	end
endmodule : testbench
